//--- include/fpo_pkg.sv
// package for the flash protect and ram overlay block: offsets, fields, reset values, states
package fpo_pkg;

    // ==========
    // register byte offsets (aligned words, data in low byte)
    localparam logic [7:0] FPO_OFF_CTRL_ONE   = 8'h00;
    localparam logic [7:0] FPO_OFF_CTRL_TWO   = 8'h04;
    localparam logic [7:0] FPO_OFF_EBLK_ONE   = 8'h08;
    localparam logic [7:0] FPO_OFF_EBLK_TWO   = 8'h0c;
    localparam logic [7:0] FPO_OFF_OVL_CTRL   = 8'h10;
    localparam logic [7:0] FPO_OFF_STATUS_TWO = 8'h14;

    // ==========
    // field positions
    localparam int FPO_CTRL_FWE_POS    = 7;  // read-only pin level
    localparam int FPO_OVL_EN_POS      = 3;  // overlap_enable
    localparam int FPO_ST_ERR_POS      = 7;  // flash_error_flag
    localparam int FPO_ST_PROG_POS     = 0;  // program mode active
    localparam int FPO_ST_ERASE_POS    = 1;  // erase mode active
    localparam int FPO_ST_BOOTNMI_POS  = 2;  // boot nmi hold active

    // ==========
    // reset values
    localparam logic [7:0] FPO_RST_BYTE    = 8'h00;
    localparam logic [2:0] FPO_RST_OVL_SEL = 3'h0;

    // ==========
    // overlay window geometry on the cpu address
    localparam int FPO_CPU_ADDR_W = 24;
    localparam int FPO_OVL_SHIFT  = 12;       // window size 2**shift bytes
    localparam int FPO_NUM_BLOCKS = 16;       // erase block select one and two

    // ==========
    // flash control one software bits
    typedef struct packed {
        logic software_write_enable;   // software_write_enable
        logic erase_setup_bit;   // erase_setup_bit
        logic program_setup_bit;   // program_setup_bit
        logic ev;    // erase_verify_bit
        logic pv;    // program_verify_bit
        logic e;     // erase mode request
        logic p;     // program mode request
    } fpo_ctrl_one_t;

    localparam fpo_ctrl_one_t FPO_RST_CTRL_ONE = 7'h00;

    // ==========
    // flash operating state, one-hot
    typedef enum logic [3:0] {
        FPO_ST_PROTECT = 4'b0001,
        FPO_ST_PROGRAM = 4'b0010,
        FPO_ST_ERASE   = 4'b0100,
        FPO_ST_ERROR   = 4'b1000
    } fpo_state_t;

endpackage : fpo_pkg

//--- rtl/fpo_flash_protect.sv
// flash program/erase protection, error protection, nmi gating and ram overlay decode
//
// Operation
// R1 - software protection blocks program/erase mode entry
// R2 - per-block erase enables; programming unaffected, verify allowed
// R3 - both erase selects zero: all blocks protected
// R4 - overlay enabled: no program, no erase
// R5 - emulation protection: no erase, selects ignored
// R6 - malfunction sets error flag, aborts mode
// R7 - error state keeps registers, blocks mode re-entry
// R8 - verify bits still work in error state
// R9 - flash read during program/erase sets error
// R10 - exception start sets error, some excluded
// R11 - sleep during program/erase sets error
// R12 - bus released during program/erase sets error
// R13 - only pin reset, watchdog, hardware standby clear error
// R14 - software standby in error initialises registers
// R15 - nmi blocked while program or erase bit set
// R16 - overlay maps ram onto selected flash block
// R17 - select zero overlays the vector block
// R18 - clearing overlay enable restores flash access
// R19 - program/erase bits cleared by reset, standby, enables
// R20 - nmi blocked in error state and emulation; nmi_block has no overlay enable term, so emulation alone does not block nmi
// R21 - boot mode holds nmi until ram branch
// R22 - processor keeps interrupts disabled while programming
// R23 - write enable pin low initialises control, selects
// R24 - reset or standby initialises all registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fpo_flash_protect
    import fpo_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      rst_b_in,
    // apb slave
    input  wire logic                      psel_in,
    input  wire logic                      penable_in,
    input  wire logic                      pwrite_in,
    input  wire logic [7:0]                paddr_in,
    input  wire logic [31:0]               pwdata_in,
    input  wire logic [3:0]                pstrb_in,
    output logic      [31:0]               prdata_out,
    output logic                           pready_out,
    output logic                           pslverr_out,
    // pins and system events
    input  wire logic                      write_enable_pin_in,
    input  wire logic                      hardware_init_pin_b_in,
    input  wire logic                      watchdog_reset_in,
    input  wire logic                      hw_standby_in,
    input  wire logic                      sw_standby_in,
    input  wire logic                      flash_read_in,
    input  wire logic                      exception_start_in,
    input  wire logic                      exception_excluded_in,
    input  wire logic                      sleep_exec_in,
    input  wire logic                      bus_release_in,
    input  wire logic                      boot_mode_in,
    input  wire logic                      boot_branch_in,
    input  wire logic                      nmi_in,
    // cpu address for the overlay decode
    input  wire logic                      cpu_valid_in,
    input  wire logic [FPO_CPU_ADDR_W-1:0] cpu_addr_in,
    // flash array control
    output logic                           program_mode_out,
    output logic                           erase_mode_out,
    output logic                           program_verify_out,
    output logic                           erase_verify_out,
    output logic      [FPO_NUM_BLOCKS-1:0] erase_block_en_out,
    output logic                           error_protect_out,
    output logic                           nmi_block_out,
    output logic                           nmi_accept_out,
    output logic                           overlay_hit_out
);

    // ==========
    // registers
    fpo_ctrl_one_t ctrl_one_q;
    logic [7:0]    ctrl_two_q;
    logic [7:0]    eblk_one_q;
    logic [7:0]    eblk_two_q;
    logic          ovl_en_q;
    logic [2:0]    ovl_sel_q;
    logic          err_flag_q;
    logic          boot_branched_q;
    fpo_state_t    state_q;
    fpo_state_t    state_d;

    logic          init_all;
    logic          init_pin;
    logic          err_clear;
    logic          wr_en;
    logic          rd_setup;
    logic          err_event;
    logic          active;
    logic [15:0]   eblk_all;
    logic          sw_ok;
    logic          prog_allow;
    logic          erase_allow;
    logic [7:0]    rd_byte;
    logic          rd_hit;
    logic [7:0]    status_byte;

    // ==========
    // reset, standby and pin initialisation terms
    assign init_all  = !hardware_init_pin_b_in || watchdog_reset_in
                       || hw_standby_in || sw_standby_in;           // R24 R14
    assign init_pin  = !write_enable_pin_in;                        // R23
    // software standby alone leaves the error flag standing
    assign err_clear = !hardware_init_pin_b_in || watchdog_reset_in || hw_standby_in; // R13

    // ==========
    // apb decode: one wait-free access, data prepared in setup
    assign rd_setup = psel_in && !penable_in;
    assign wr_en    = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];

    // program/erase in progress, as seen by the error detector
    assign active = (state_q == FPO_ST_PROGRAM) || (state_q == FPO_ST_ERASE);

    // ==========
    // flash control one; p/e cleared whenever the enables drop
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_one_q <= FPO_RST_CTRL_ONE;
        end else if (init_all || init_pin) begin
            ctrl_one_q <= FPO_RST_CTRL_ONE;                         // R23 R24 R19
        end else if (wr_en && paddr_in == FPO_OFF_CTRL_ONE) begin
            // bits stay writable in error state, mode entry is refused later
            ctrl_one_q   <= fpo_ctrl_one_t'(pwdata_in[6:0]);        // R7
            if (!pwdata_in[6]) begin
                ctrl_one_q.p <= 1'b0;                               // R19
                ctrl_one_q.e <= 1'b0;                               // R19
            end
        end else if (!ctrl_one_q.software_write_enable) begin
            ctrl_one_q.p <= 1'b0;                                   // R19
            ctrl_one_q.e <= 1'b0;                                   // R19
        end
    end

    // ==========
    // flash control two, plain byte cleared by reset and standby
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_two_q <= FPO_RST_BYTE;
        end else if (init_all) begin
            ctrl_two_q <= FPO_RST_BYTE;                             // R24
        end else if (wr_en && paddr_in == FPO_OFF_CTRL_TWO) begin
            ctrl_two_q <= pwdata_in[7:0];
        end
    end

    // ==========
    // erase block selects
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            eblk_one_q <= FPO_RST_BYTE;
            eblk_two_q <= FPO_RST_BYTE;
        end else if (init_all || init_pin) begin
            eblk_one_q <= FPO_RST_BYTE;                             // R23 R24 R14
            eblk_two_q <= FPO_RST_BYTE;
        end else if (wr_en) begin
            if (paddr_in == FPO_OFF_EBLK_ONE) begin
                eblk_one_q <= pwdata_in[7:0];                       // R2
            end
            if (paddr_in == FPO_OFF_EBLK_TWO) begin
                eblk_two_q <= pwdata_in[7:0];                       // R2
            end
        end
    end

    // ==========
    // overlay control; not touched by the write enable pin
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovl_en_q  <= 1'b0;
            ovl_sel_q <= FPO_RST_OVL_SEL;
        end else if (init_all) begin
            ovl_en_q  <= 1'b0;
            ovl_sel_q <= FPO_RST_OVL_SEL;
        end else if (wr_en && paddr_in == FPO_OFF_OVL_CTRL) begin
            ovl_en_q  <= pwdata_in[FPO_OVL_EN_POS];                 // R16 R18
            ovl_sel_q <= pwdata_in[2:0];
        end
    end

    // ==========
    // protection terms
    assign eblk_all    = {eblk_two_q, eblk_one_q};
    assign sw_ok       = ctrl_one_q.software_write_enable && write_enable_pin_in;
    // overlay on means emulation protection for every block
    assign prog_allow  = sw_ok && !ovl_en_q;                        // R1 R4
    assign erase_allow = sw_ok && !ovl_en_q && (eblk_all != 16'h0000); // R1 R3 R5

    // ==========
    // error detection: any misbehaviour while a mode is live
    assign err_event = active && (flash_read_in                     // R9
                       || (exception_start_in && !exception_excluded_in) // R10
                       || sleep_exec_in                             // R11
                       || bus_release_in);                          // R12

    // error flag: setting wins over every clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_flag_q <= 1'b0;
        end else if (err_event) begin
            err_flag_q <= 1'b1;                                     // R6
        end else if (err_clear) begin
            err_flag_q <= 1'b0;                                     // R13
        end
    end

    // ==========
    // operating state
    always_comb begin
        state_d = state_q;
        case (state_q)
            FPO_ST_PROTECT: begin
                if (ctrl_one_q.p && prog_allow) begin
                    state_d = FPO_ST_PROGRAM;
                end else if (ctrl_one_q.e && erase_allow) begin
                    state_d = FPO_ST_ERASE;
                end
            end
            FPO_ST_PROGRAM: begin
                if (err_event) begin
                    state_d = FPO_ST_ERROR;                         // R6
                end else if (!(ctrl_one_q.p && prog_allow)) begin
                    state_d = FPO_ST_PROTECT;                       // R19
                end
            end
            FPO_ST_ERASE: begin
                if (err_event) begin
                    state_d = FPO_ST_ERROR;                         // R6
                end else if (!(ctrl_one_q.e && erase_allow)) begin
                    state_d = FPO_ST_PROTECT;                       // R19
                end
            end
            FPO_ST_ERROR: begin
                // p/e writes cannot bring a mode back from here
                if (err_clear) begin
                    state_d = FPO_ST_PROTECT;                       // R13 R7
                end
            end
            default: begin
                state_d = FPO_ST_PROTECT;
            end
        endcase
        // init aborts a live mode, an error at the same edge wins
        if (init_all && state_d != FPO_ST_ERROR) begin
            state_d = FPO_ST_PROTECT;                               // R24
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= FPO_ST_PROTECT;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========
    // mode and verify outputs, registered
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            program_mode_out   <= 1'b0;
            erase_mode_out     <= 1'b0;
            program_verify_out <= 1'b0;
            erase_verify_out   <= 1'b0;
            error_protect_out  <= 1'b0;
        end else begin
            program_mode_out   <= (state_d == FPO_ST_PROGRAM) && !err_event; // R1 R6
            erase_mode_out     <= (state_d == FPO_ST_ERASE) && !err_event;   // R5 R6
            // verify stays open in error protection
            program_verify_out <= ctrl_one_q.pv && sw_ok;           // R2 R8
            erase_verify_out   <= ctrl_one_q.ev && sw_ok;           // R8
            error_protect_out  <= (state_d == FPO_ST_ERROR);        // R6
        end
    end

    // ==========
    // per-block erase strobes, only during erase mode
    generate
        for (genvar gi = 0; gi < FPO_NUM_BLOCKS; gi++) begin : g_eblk
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    erase_block_en_out[gi] <= 1'b0;
                end else begin
                    erase_block_en_out[gi] <= eblk_all[gi] && (state_d == FPO_ST_ERASE)
                                              && !err_event;        // R2 R5
                end
            end
        end
    endgenerate

    // ==========
    // boot nmi hold: released once by the branch into ram
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            boot_branched_q <= 1'b0;
        end else if (init_all) begin
            boot_branched_q <= 1'b0;
        end else if (boot_branch_in) begin
            boot_branched_q <= 1'b1;                                // R21
        end
    end

    // ==========
    // nmi gating; the raw bits count, not just live modes
    logic nmi_block;
    assign nmi_block = ctrl_one_q.p || ctrl_one_q.e                 // R15 R20
                       || err_flag_q || (state_q == FPO_ST_ERROR)   // R20
                       || (boot_mode_in && !boot_branched_q);       // R21

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nmi_block_out  <= 1'b1;
            nmi_accept_out <= 1'b0;
        end else begin
            nmi_block_out  <= nmi_block;
            nmi_accept_out <= nmi_in && !nmi_block;                 // R15 R21
        end
    end

    // ==========
    // overlay decode: window index equals select, zero is vector block
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            overlay_hit_out <= 1'b0;
        end else begin
            overlay_hit_out <= ovl_en_q && cpu_valid_in             // R16 R18
                               && cpu_addr_in[FPO_CPU_ADDR_W-1:FPO_OVL_SHIFT]
                                  == {{(FPO_CPU_ADDR_W-FPO_OVL_SHIFT-3){1'b0}}, ovl_sel_q}; // R17
        end
    end

    // ==========
    // read mux
    always_comb begin
        status_byte = 8'h00;
        status_byte[FPO_ST_ERR_POS]     = err_flag_q;
        status_byte[FPO_ST_PROG_POS]    = (state_q == FPO_ST_PROGRAM);
        status_byte[FPO_ST_ERASE_POS]   = (state_q == FPO_ST_ERASE);
        status_byte[FPO_ST_BOOTNMI_POS] = boot_mode_in && !boot_branched_q;
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (paddr_in)
            FPO_OFF_CTRL_ONE:   rd_byte = {write_enable_pin_in, ctrl_one_q};
            FPO_OFF_CTRL_TWO:   rd_byte = ctrl_two_q;
            FPO_OFF_EBLK_ONE:   rd_byte = eblk_one_q;
            FPO_OFF_EBLK_TWO:   rd_byte = eblk_two_q;
            FPO_OFF_OVL_CTRL:   rd_byte = {4'h0, ovl_en_q, ovl_sel_q};
            FPO_OFF_STATUS_TWO: rd_byte = status_byte;
            default:            rd_hit  = 1'b0;
        endcase
    end

    // ==========
    // apb answer: ready in the first access cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
        end else begin
            pready_out <= rd_setup;
            if (rd_setup) begin
                // unmapped or status writes report an error, no effect
                pslverr_out <= !rd_hit || (pwrite_in && paddr_in == FPO_OFF_STATUS_TWO);
                prdata_out  <= pwrite_in ? 32'h00000000 : {24'h000000, rd_byte};
            end else begin
                pslverr_out <= 1'b0;
                prdata_out  <= 32'h00000000;
            end
        end
    end

endmodule : fpo_flash_protect

`default_nettype wire

//--- tb/fpo_flash_protect_sva.sv
// assertions on the ports of the flash protect block
`timescale 1ns/1ps
`default_nettype none
module fpo_flash_protect_sva (
    input wire logic clk_in, rst_b_in, pready_out, write_enable_pin_in, hardware_init_pin_b_in,
    input wire logic watchdog_reset_in, hw_standby_in, flash_read_in, exception_start_in,
    input wire logic exception_excluded_in, sleep_exec_in, bus_release_in,
    input wire logic program_mode_out, erase_mode_out, error_protect_out, nmi_block_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // ==========
    // an error event while a mode is active; it wins over any init
    sequence pe_event(ev);
        (program_mode_out || erase_mode_out) && ev;
    endsequence

    AST_ERR_READ: assert property (pe_event(flash_read_in) |=> error_protect_out)
        else $error("flash read in mode left error clear");
    AST_ERR_EXC: assert property (pe_event(exception_start_in && !exception_excluded_in) |=> error_protect_out)
        else $error("exception in mode left error clear");
    AST_ERR_SLEEP: assert property (pe_event(sleep_exec_in) |=> error_protect_out)
        else $error("sleep in mode left error clear");
    AST_ERR_BUS: assert property (pe_event(bus_release_in) |=> error_protect_out)
        else $error("bus release in mode left error clear");
    AST_ERR_NOMODE: assert property (error_protect_out |-> !program_mode_out && !erase_mode_out)
        else $error("mode active during error protection");
    AST_ERR_HOLD: assert property (error_protect_out && hardware_init_pin_b_in && !watchdog_reset_in
        && !hw_standby_in |=> error_protect_out)
        else $error("error protection left without init");
    AST_ERR_CLR: assert property (error_protect_out && watchdog_reset_in |=> !error_protect_out)
        else $error("watchdog init kept error protection");
    AST_NMI_PE: assert property (program_mode_out || erase_mode_out |-> nmi_block_out)
        else $error("nmi open during program or erase");
    AST_NMI_ERR: assert property (error_protect_out |-> nmi_block_out)
        else $error("nmi open during error protection");
    AST_PIN_LOW: assert property (!write_enable_pin_in [*3] |-> !program_mode_out && !erase_mode_out)
        else $error("mode active with write enable low");
    AST_READY_ONE: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
endmodule : fpo_flash_protect_sva

bind fpo_flash_protect fpo_flash_protect_sva u_sva (.*);
`default_nettype wire

//--- tb/fpo_cpu_model.sv
// processor side model: error events, nmi requests and overlay addresses
`timescale 1ns/1ps
`default_nettype none
module fpo_cpu_model
    import fpo_pkg::*;
(
    input  wire logic                      clk_in, rst_b_in, fire_in, nmi_req_in, pe_in, cv_in,
    input  wire logic [2:0]                code_in,
    input  wire logic [FPO_CPU_ADDR_W-1:0] addr_in,
    output logic                           rd_out, exs_out, exx_out, slp_out, bus_out, nmi_out, cv_out,
    output logic      [FPO_CPU_ADDR_W-1:0] addr_out
);
    // ==========
    // one-cycle event pulses; codes 0 read, 1 exception, 2 sleep, 3 bus, 4 excluded exception
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {rd_out, exs_out, exx_out, slp_out, bus_out, nmi_out, cv_out} <= '0;
            addr_out <= '0;
        end else begin
            rd_out  <= fire_in && code_in == 3'h0;
            exs_out <= fire_in && (code_in == 3'h1 || code_in == 3'h4);
            exx_out <= fire_in && code_in == 3'h4;
            slp_out <= fire_in && code_in == 3'h2;
            bus_out <= fire_in && code_in == 3'h3;
            nmi_out <= nmi_req_in && !pe_in;
            cv_out  <= cv_in;
            addr_out <= cv_in ? addr_in : ~addr_out; // idle address keeps moving
        end
    end
endmodule : fpo_cpu_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the flash protect block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fpo_pkg::*;
    logic        clk_in, rst_b_in, psel, pen, pwr, pready, pslverr, sl, pin, hinit_b, wdog, hstby, sstby;
    logic        boot, branch, nreq, fire, cv, frd, exs, exx, slp, bus, nmi, cpuv, pm, em, pv, ev, err, nb, na, hit;
    logic [2:0]  code, s;
    logic [7:0]  paddr, v;
    logic [15:0] eblk;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] caddr, cpua;
    int          fail_count, samples_checked;

    fpo_flash_protect dut (.clk_in, .rst_b_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .write_enable_pin_in(pin), .hardware_init_pin_b_in(hinit_b),
        .watchdog_reset_in(wdog), .hw_standby_in(hstby), .sw_standby_in(sstby), .flash_read_in(frd),
        .exception_start_in(exs), .exception_excluded_in(exx), .sleep_exec_in(slp), .bus_release_in(bus),
        .boot_mode_in(boot), .boot_branch_in(branch), .nmi_in(nmi), .cpu_valid_in(cpuv), .cpu_addr_in(cpua),
        .program_mode_out(pm), .erase_mode_out(em), .program_verify_out(pv), .erase_verify_out(ev),
        .erase_block_en_out(eblk), .error_protect_out(err), .nmi_block_out(nb), .nmi_accept_out(na),
        .overlay_hit_out(hit));
    fpo_cpu_model u_cpu (.clk_in, .rst_b_in, .fire_in(fire), .nmi_req_in(nreq), .pe_in(pm | em), .cv_in(cv),
        .code_in(code), .addr_in(caddr), .rd_out(frd), .exs_out(exs), .exx_out(exx), .slp_out(slp),
        .bus_out(bus), .nmi_out(nmi), .cv_out(cpuv), .addr_out(cpua));

    // ==========
    // clock, watchdog and shared tasks
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        conclude();
    end
    task automatic conclude();
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask : wt
    // request held until the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    // ==========
    // main sequence
    initial begin
        {psel, pen, pwr, wdog, hstby, sstby, branch, nreq, fire, cv, rst_b_in} = '0;
        {pin, hinit_b, boot} = 3'h7;
        {paddr, pwdata, code, caddr, fail_count, samples_checked} = '0;
        void'($urandom(64736));
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        nreq <= 1'b1;
        wt(2);
        chk("nmi_block", 1, nb);
        chk("nmi_accept", 0, na);
        @(posedge clk_in) branch <= 1'b1;
        @(posedge clk_in) branch <= 1'b0;
        boot <= 1'b0;
        wt(3);
        chk("nmi_accept", 1, na);
        @(posedge clk_in) nreq <= 1'b0;
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk("reset value", (a == 0) ? 32'h80 : 32'h0, rd);
            chk("slverr", a == 6, sl);
        end
        apb(1'b1, FPO_OFF_CTRL_ONE, 32'h42);
        wt(1);
        chk("erase_mode", 0, em);
        v = 8'($urandom_range(1, 255));
        apb(1'b1, FPO_OFF_EBLK_ONE, {24'h0, v});
        apb(1'b1, FPO_OFF_CTRL_ONE, 32'h42);
        wt(1);
        chk("erase_mode", 1, em);
        chk("erase_blocks", {24'h0, v}, eblk);
        chk("nmi_block", 1, nb);
        apb(1'b1, FPO_OFF_CTRL_ONE, 32'h48);
        wt(1);
        chk("erase_verify", 1, ev);
        // every error source in program mode, cleared by watchdog, hardware standby or init pin, not by software standby
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, FPO_OFF_CTRL_ONE, 32'h41);
            wt(1);
            @(posedge clk_in) fire <= 1'b1;
            code <= 3'(i);
            @(posedge clk_in) fire <= 1'b0;
            wt(1);
            chk("error_flag", i != 4, err);
            chk("program_mode", i == 4, pm);
            if (i < 4) begin
                apb(1'b0, FPO_OFF_STATUS_TWO, 32'h0);
                chk("status", 32'h80, rd & 32'h80);
                apb(1'b1, FPO_OFF_CTRL_ONE, 32'h45);
                wt(1);
                chk("program_mode", 0, pm);
                chk("program_verify", 1, pv);
                @(posedge clk_in) sstby <= 1'b1;
                @(posedge clk_in) sstby <= 1'b0;
                apb(1'b0, FPO_OFF_CTRL_ONE, 32'h0);
                chk("ctrl_one", 32'h80, rd);
                chk("error_flag", 1, err);
                @(posedge clk_in) {wdog, hstby, hinit_b} <= {i % 3 == 0, i % 3 == 1, i % 3 != 2};
                @(posedge clk_in) {wdog, hstby, hinit_b} <= 3'h1;
                wt(1);
                chk("error_flag", 0, err);
            end else apb(1'b1, FPO_OFF_CTRL_ONE, 32'h0);
        end
        // overlay on the vector block, then on a random block
        for (int k = 0; k < 2; k++) begin
            s = (k == 0) ? 3'h0 : 3'($urandom_range(1, 7));
            apb(1'b1, FPO_OFF_OVL_CTRL, {28'h0, 1'b1, s});
            apb(1'b1, FPO_OFF_CTRL_ONE, 32'h41);
            @(posedge clk_in) cv <= 1'b1;
            caddr <= {9'h0, s, 12'($urandom)};
            wt(2);
            chk("overlay_hit", 1, hit);
            chk("program_mode", 0, pm);
            chk("nmi_block", 1, nb);
            apb(1'b1, FPO_OFF_CTRL_ONE, 32'h0);
            apb(1'b1, FPO_OFF_OVL_CTRL, 32'h0);
            wt(1);
            chk("overlay_hit", 0, hit);
        end
        apb(1'b1, FPO_OFF_EBLK_TWO, 32'hff);
        apb(1'b1, FPO_OFF_CTRL_ONE, 32'h41);
        wt(1);
        chk("program_mode", 1, pm);
        @(posedge clk_in) pin <= 1'b0;
        wt(3);
        chk("program_mode", 0, pm);
        @(posedge clk_in) pin <= 1'b1;
        apb(1'b0, FPO_OFF_EBLK_TWO, 32'h0);
        chk("erase_sel_two", 0, rd);
        conclude();
    end
endmodule : testbench
`default_nettype wire
